// ==== design/sfct_pkg.sv ====
// Package of constants for the serial flash command sequencer.
// Assumes a 50 MHz system clock and a host that owns the serial clock.
package sfct_pkg;
    // ====================================================================
    // Clock and timing
    localparam int CLK_MHZ = 50;
    localparam int PAGE_TRANSFER_TIME_US = 150;
    localparam int PROG_ERASE_TIME_MS = 20;
    localparam int PROG_ONLY_TIME_MS = 14;
    localparam int PAGE_ERASE_TIME_MS = 8;
    localparam int BLOCK_ERASE_TIME_MS = 12;
    localparam int RESET_RECOVERY_US = 1;
    localparam int BUSY_LOW_NS = 200;
    localparam int XFER_CYC = PAGE_TRANSFER_TIME_US * CLK_MHZ;
    localparam int PROG_ERASE_CYC = PROG_ERASE_TIME_MS * 1000 * CLK_MHZ;
    localparam int PROG_ONLY_CYC = PROG_ONLY_TIME_MS * 1000 * CLK_MHZ;
    localparam int PAGE_ERASE_CYC = PAGE_ERASE_TIME_MS * 1000 * CLK_MHZ;
    localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_MS * 1000 * CLK_MHZ;
    localparam int RECOVER_CYC = RESET_RECOVERY_US * CLK_MHZ;
    localparam int BUSY_LOW_CYC = BUSY_LOW_NS * CLK_MHZ / 1000;
    // ====================================================================
    // Opcodes
    localparam logic [7:0] OP_ARRAY_RD_IDLE = 8'h68;
    localparam logic [7:0] OP_ARRAY_RD_SPI = 8'he8;
    localparam logic [7:0] OP_PAGE_RD_IDLE = 8'h52;
    localparam logic [7:0] OP_PAGE_RD_SPI = 8'hd2;
    localparam logic [7:0] OP_BUF1_RD_IDLE = 8'h54;
    localparam logic [7:0] OP_BUF2_RD_IDLE = 8'h56;
    localparam logic [7:0] OP_BUF1_RD_SPI = 8'hd4;
    localparam logic [7:0] OP_BUF2_RD_SPI = 8'hd6;
    localparam logic [7:0] OP_STATUS_IDLE = 8'h57;
    localparam logic [7:0] OP_STATUS_SPI = 8'hd7;
    localparam logic [7:0] OP_XFER_BUF1 = 8'h53;
    localparam logic [7:0] OP_XFER_BUF2 = 8'h55;
    localparam logic [7:0] OP_CMP_BUF1 = 8'h60;
    localparam logic [7:0] OP_CMP_BUF2 = 8'h61;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] OP_PROG_ERASE_B1 = 8'h83;
    localparam logic [7:0] OP_PROG_ERASE_B2 = 8'h86;
    localparam logic [7:0] OP_PROG_ONLY_B1 = 8'h88;
    localparam logic [7:0] OP_PROG_ONLY_B2 = 8'h89;
    // ====================================================================
    // Framing
    localparam int BYTE_BITS = 8;
    localparam int ADDR_BYTES = 3;
    localparam int ARRAY_DUMMY = 4;
    localparam int BUF_DUMMY = 1;
    localparam int RSV_BITS = 3;
    localparam int PAGE_BITS = 12;
    localparam int BYTE_ADDR_BITS = 9;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] STATUS_ID = 8'h24; // Arbitrary density code.
    // ====================================================================
    typedef enum logic [1:0] {SFCT_CLK_IDLE_LOW, SFCT_CLK_IDLE_HIGH}
        sfct_mode_t;
    typedef enum logic [2:0] {
        SFCT_OPC, SFCT_ADDR, SFCT_DUMMY, SFCT_DATA, SFCT_WAIT
    } sfct_phase_t;
endpackage : sfct_pkg

// ==== design/sfct_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock; the reader may stall and back-pressure the writer.
`timescale 1ns/1ps
module sfct_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic wr, rd;
    always_comb begin
        in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
        out_valid = wp_r != rp_r;
        out_data = mem[rp_r[AW-1:0]];
        wr = in_valid && in_ready;
        rd = out_valid && out_ready;
        wp_nxt = wp_r + (AW+1)'(wr);
        rp_nxt = rp_r + (AW+1)'(rd);
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
        if (wr) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule : sfct_fifo

// ==== design/sfct_core.sv ====
// Serial command front end and busy timer of a page-organised flash.
// Assumes the host drives select, clock and data; pins are asynchronous.
// Read data arrives from the array through rd_data and the FIFO.
`timescale 1ns/1ps
module sfct_core #(
    parameter int PROG_ERASE_CYCLES = sfct_pkg::PROG_ERASE_CYC,
    parameter int PROG_ONLY_CYCLES = sfct_pkg::PROG_ONLY_CYC,
    parameter int PAGE_ERASE_CYCLES = sfct_pkg::PAGE_ERASE_CYC,
    parameter int BLOCK_ERASE_CYCLES = sfct_pkg::BLOCK_ERASE_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic si_pin,
    input wire logic reset_n_pin,
    output logic so_out,
    output logic so_oe,
    output logic ready_busy_n,
    output logic [14:0] page_addr,
    output logic [8:0] byte_addr,
    output logic buf_sel,
    output logic rd_req,
    output logic clk_mode,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    output logic rd_ready
);
    import sfct_pkg::*;
    // ====================================================================
    // Pin synchronisers.
    logic [1:0] cs_s_r, sck_s_r, si_s_r, rst_s_r;
    logic sck_d_r;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cs_s_r <= 2'h3;
            sck_s_r <= 2'h0;
            si_s_r <= 2'h0;
            rst_s_r <= 2'h0;
            sck_d_r <= 1'b0;
        end else begin
            cs_s_r <= {cs_s_r[0], cs_n_pin};
            sck_s_r <= {sck_s_r[0], sck_pin};
            si_s_r <= {si_s_r[0], si_pin};
            rst_s_r <= {rst_s_r[0], reset_n_pin};
            sck_d_r <= sck_s_r[1];
        end
    end
    logic cs_n, sck_rise, sck_fall, pin_rst;
    assign cs_n = cs_s_r[1];
    assign sck_rise = sck_s_r[1] && !sck_d_r;
    assign sck_fall = !sck_s_r[1] && sck_d_r;
    assign pin_rst = !rst_s_r[1];
    logic cs_d_r;
    always_ff @(posedge sys_clk) begin
        cs_d_r <= srst ? 1'b1 : cs_n;
    end
    logic cs_fall, cs_rise;
    assign cs_fall = cs_d_r && !cs_n;
    assign cs_rise = !cs_d_r && cs_n;
    // ====================================================================
    // Read data buffer; shifting never waits, so an empty buffer sends whatever it holds at the read pointer.
    logic [7:0] fifo_data;
    logic fifo_valid, fifo_pop, fifo_in_ready;
    logic rdrdy_r;
    sfct_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst || pin_rst),
        .in_data(rd_data),
        .in_valid(rd_valid && rdrdy_r),
        .in_ready(fifo_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );
    // ====================================================================
    // Command state.
    sfct_phase_t ph_r, ph_nxt;
    logic [7:0] sh_r, sh_nxt, op_r, op_nxt, out_r, out_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic mode_r, mode_nxt;
    logic so_r, so_nxt, oe_r, oe_nxt, req_r, req_nxt;
    logic start_r, start_nxt;
    logic [31:0] busy_r, busy_nxt, rec_r, rec_nxt, tlen;
    logic [31:0] blen_r, blen_nxt, run_r, run_nxt;
    logic rdy_r, rdy_nxt;
    logic [7:0] opc;
    logic is_status, is_array, is_page, is_buf, timed;
    always_comb begin
        opc = {sh_r[6:0], si_s_r[1]};
        is_status = opc == OP_STATUS_IDLE || opc == OP_STATUS_SPI;
        is_array = op_r == OP_ARRAY_RD_IDLE || op_r == OP_ARRAY_RD_SPI;
        is_page = op_r == OP_PAGE_RD_IDLE || op_r == OP_PAGE_RD_SPI;
        is_buf = op_r == OP_BUF1_RD_IDLE || op_r == OP_BUF2_RD_IDLE ||
                 op_r == OP_BUF1_RD_SPI || op_r == OP_BUF2_RD_SPI;
        case (op_r)
            OP_XFER_BUF1, OP_XFER_BUF2, OP_CMP_BUF1, OP_CMP_BUF2:
                tlen = 32'(XFER_CYC);
            OP_PROG_ERASE_B1, OP_PROG_ERASE_B2: tlen = 32'(PROG_ERASE_CYCLES);
            OP_PROG_ONLY_B1, OP_PROG_ONLY_B2: tlen = 32'(PROG_ONLY_CYCLES);
            OP_PAGE_ERASE: tlen = 32'(PAGE_ERASE_CYCLES);
            OP_BLOCK_ERASE: tlen = 32'(BLOCK_ERASE_CYCLES);
            default: tlen = 32'h0;
        endcase
        timed = tlen != 32'h0;
    end
    always_comb begin
        ph_nxt = ph_r;
        sh_nxt = sh_r;
        op_nxt = op_r;
        out_nxt = out_r;
        bit_nxt = bit_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        mode_nxt = mode_r;
        so_nxt = so_r;
        oe_nxt = oe_r;
        req_nxt = 1'b0;
        start_nxt = 1'b0;
        busy_nxt = busy_r;
        rec_nxt = rec_r;
        rdy_nxt = rdy_r;
        run_nxt = run_r;
        blen_nxt = rdy_r ? 32'h0 : blen_r + 32'h1;
        fifo_pop = 1'b0;
        if (rec_r != 32'h0) begin
            rec_nxt = rec_r - 32'h1;
        end
        if (busy_r > 32'h1) begin
            busy_nxt = busy_r - 32'h1;
        end else if (busy_r == 32'h1) begin
            busy_nxt = 32'h0;
            rdy_nxt = 1'b1;
        end
        if (cs_n) begin
            oe_nxt = 1'b0;
            ph_nxt = SFCT_OPC;
            bit_nxt = 3'h0;
            if (cs_rise && ph_r == SFCT_WAIT && timed && rdy_r) begin
                busy_nxt = tlen;
                rdy_nxt = 1'b0;
                run_nxt = tlen;
            end
        end else if (rec_r == 32'h0) begin
            if (cs_fall) begin
                mode_nxt = sck_s_r[1];
            end
            if (sck_rise && ph_r != SFCT_DATA) begin
                sh_nxt = opc;
                bit_nxt = bit_r + 3'h1;
                if (bit_r == 3'(BYTE_BITS - 1)) begin
                    case (ph_r)
                        SFCT_OPC: begin
                            op_nxt = opc;
                            cnt_nxt = 3'h0;
                            ph_nxt = is_status ? SFCT_DATA : SFCT_ADDR;
                            start_nxt = is_status;
                        end
                        SFCT_ADDR: begin
                            addr_nxt = {addr_r[15:0], opc};
                            cnt_nxt = cnt_r + 3'h1;
                            if (cnt_r == 3'(ADDR_BYTES - 1)) begin
                                cnt_nxt = 3'h0;
                                if (is_array || is_page || is_buf) begin
                                    ph_nxt = SFCT_DUMMY;
                                    req_nxt = 1'b1;
                                end else begin
                                    ph_nxt = SFCT_WAIT;
                                end
                            end
                        end
                        SFCT_DUMMY: begin
                            cnt_nxt = cnt_r + 3'h1;
                            if (cnt_r == 3'(is_buf ? BUF_DUMMY - 1
                                                   : ARRAY_DUMMY - 1)) begin
                                ph_nxt = SFCT_DATA;
                                start_nxt = 1'b1;
                            end
                        end
                        default: ph_nxt = ph_r;
                    endcase
                end
            end else if (ph_r == SFCT_DATA) begin
                // Input is ignored here; bytes leave MSB first.
                if (start_r) begin
                    out_nxt = op_r == OP_STATUS_IDLE || op_r == OP_STATUS_SPI
                        ? {rdy_r, STATUS_ID[6:0]} : fifo_data;
                    fifo_pop = !(op_r == OP_STATUS_IDLE ||
                                 op_r == OP_STATUS_SPI) && fifo_valid;
                    bit_nxt = 3'h0;
                end else if (sck_fall) begin
                    so_nxt = out_r[3'h7 - bit_r];
                    oe_nxt = 1'b1;
                    bit_nxt = bit_r + 3'h1;
                    if (bit_r == 3'h7) begin
                        out_nxt = (op_r == OP_STATUS_IDLE ||
                                   op_r == OP_STATUS_SPI)
                            ? {rdy_r, STATUS_ID[6:0]} : fifo_data;
                        fifo_pop = fifo_valid && !(op_r == OP_STATUS_IDLE ||
                                                   op_r == OP_STATUS_SPI);
                    end
                end
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst || pin_rst) begin
            ph_r <= SFCT_OPC;
            sh_r <= 8'h0;
            op_r <= 8'h0;
            out_r <= 8'h0;
            bit_r <= 3'h0;
            cnt_r <= 3'h0;
            addr_r <= 24'h0;
            mode_r <= 1'b0;
            so_r <= 1'b0;
            oe_r <= 1'b0;
            req_r <= 1'b0;
            start_r <= 1'b0;
            busy_r <= 32'h0;
            rec_r <= 32'(RECOVER_CYC);
            rdy_r <= 1'b1;
            blen_r <= 32'h0;
            run_r <= 32'h0;
        end else begin
            ph_r <= ph_nxt;
            sh_r <= sh_nxt;
            op_r <= op_nxt;
            out_r <= out_nxt;
            bit_r <= bit_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            mode_r <= mode_nxt;
            so_r <= so_nxt;
            oe_r <= oe_nxt;
            req_r <= req_nxt;
            start_r <= start_nxt;
            busy_r <= busy_nxt;
            rec_r <= rec_nxt;
            rdy_r <= rdy_nxt;
            blen_r <= blen_nxt;
            run_r <= run_nxt;
        end
    end
    // ====================================================================
    // Outputs. Reserved bits widen the page address for bigger arrays.
    logic [14:0] pa_r;
    logic [8:0] ba_r;
    logic bsel_r;
    always_ff @(posedge sys_clk) begin
        if (srst || pin_rst) begin
            pa_r <= 15'h0;
            ba_r <= 9'h0;
            bsel_r <= 1'b0;
            rdrdy_r <= 1'b0;
        end else begin
            pa_r <= addr_r[23:9];
            ba_r <= addr_r[8:0];
            bsel_r <= op_r[1];
            // Ready drops after each taken byte, so a full buffer is safe.
            rdrdy_r <= fifo_in_ready && !(rd_valid && rdrdy_r);
        end
    end
    assign so_out = so_r;
    assign so_oe = oe_r;
    assign ready_busy_n = rdy_r;
    assign page_addr = pa_r;
    assign byte_addr = ba_r;
    assign buf_sel = bsel_r;
    assign rd_req = req_r;
    assign clk_mode = mode_r;
    assign rd_ready = rdrdy_r;
    // ====================================================================
    // Checks. Busy runs are counted in helper state, not in long delays.
    property p_busy_fast;
        @(posedge sys_clk) disable iff (srst || pin_rst)
        (cs_rise && ph_r == SFCT_WAIT && timed && rdy_r)
            |=> !ready_busy_n;
    endproperty
    a_busy_fast: assert property (p_busy_fast)
        else $error("Busy did not fall after select rose.");
    property p_xfer_len;
        @(posedge sys_clk) disable iff (srst || pin_rst)
        ($rose(rdy_r) && run_r == 32'(XFER_CYC)) |-> blen_r == 32'(XFER_CYC);
    endproperty
    a_xfer_len: assert property (p_xfer_len)
        else $error("Transfer busy period had the wrong length.");
    property p_busy_len;
        @(posedge sys_clk) disable iff (srst || pin_rst)
        ($rose(rdy_r) && run_r != 32'(XFER_CYC)) |-> blen_r == run_r;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("Busy period length differs from the operation.");
    property p_rec_idle;
        @(posedge sys_clk) disable iff (srst || pin_rst)
        (rec_r != 32'h0) |-> (ph_r == SFCT_OPC && !so_oe);
    endproperty
    a_rec_idle: assert property (p_rec_idle)
        else $error("Command activity during reset recovery.");
    property p_so_hold;
        @(posedge sys_clk) disable iff (srst || pin_rst)
        $changed(so_out) |-> ph_r == SFCT_DATA;
    endproperty
    a_so_hold: assert property (p_so_hold)
        else $error("Serial output moved outside the data phase.");
    property p_oe_off;
        @(posedge sys_clk) disable iff (srst || pin_rst)
        cs_n |=> !so_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("Output driven while deselected.");
endmodule : sfct_core

// ==== sim/sfct_host.sv ====
// Host controller model that drives the four-wire serial bus.
// Assumes the bench calls its tasks; every pin moves on a sys_clk fall.
`timescale 1ns/1ps
module sfct_host (
    input wire logic sys_clk,
    output logic cs_n_pin,
    output logic sck_pin,
    output logic si_pin,
    input wire logic so_out
);
    import sfct_pkg::*;
    // ====================================================================
    // Serial clock of 160 ns, four system cycles each half.
    localparam int HALF = 4;
    // Select setup and high time of 250 ns rounded up to whole cycles.
    localparam int CS_GAP = 13;
    logic idle_high;

    initial begin
        cs_n_pin = 1'b1;
        sck_pin = 1'b0;
        si_pin = 1'b0;
        idle_high = 1'b0;
    end

    task automatic wait_half();
        repeat (HALF) @(negedge sys_clk);
    endtask : wait_half

    // The clock stands still at its idle level outside frames.
    task automatic frame_start(input logic md);
        @(negedge sys_clk);
        idle_high = md;
        sck_pin = md;
        repeat (CS_GAP) @(negedge sys_clk);
        cs_n_pin = 1'b0;
        repeat (CS_GAP) @(negedge sys_clk);
    endtask : frame_start

    // One byte, MSB first, eight clocks; input is taken on the rise.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck_pin = 1'b0;
            si_pin = tx[i];
            wait_half();
            rx[i] = so_out;
            sck_pin = 1'b1;
            wait_half();
        end
    endtask : xfer

    // A released data line shows the inverse of its last value.
    task automatic frame_end();
        sck_pin = idle_high;
        wait_half();
        cs_n_pin = 1'b1;
        si_pin = ~si_pin;
    endtask : frame_end
endmodule : sfct_host

// ==== sim/serial_flash_command_timing_test.sv ====
// Self-checking bench of the serial flash command sequencer and FIFO.
// Assumes the host model sfct_host and a 50 MHz system clock.
`timescale 1ns/1ps
module serial_flash_command_timing_test;
    import sfct_pkg::*;
    // Busy lengths are shortened to keep the run brief.
    localparam int PE_N = 400;
    localparam int PO_N = 300;
    localparam int ER_N = 200;
    localparam int BE_N = 250;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic reset_n_pin = 1'b1;
    logic [7:0] rd_data = 8'h00;
    logic rd_valid = 1'b0;
    logic cs_n_pin, sck_pin, si_pin, so_out, so_oe, ready_busy_n;
    logic [14:0] page_addr;
    logic [8:0] byte_addr;
    logic buf_sel, rd_req, clk_mode, rd_ready;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int req_seen = 0;
    logic [7:0] ops [8] = '{OP_ARRAY_RD_IDLE, OP_PAGE_RD_IDLE,
        OP_BUF1_RD_IDLE, OP_BUF2_RD_IDLE, OP_ARRAY_RD_SPI, OP_PAGE_RD_SPI,
        OP_BUF1_RD_SPI, OP_BUF2_RD_SPI};

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (rd_req === 1'b1) begin
            req_seen <= req_seen + 1;
        end
    end

    sfct_core #(.PROG_ERASE_CYCLES(PE_N), .PROG_ONLY_CYCLES(PO_N),
        .PAGE_ERASE_CYCLES(ER_N), .BLOCK_ERASE_CYCLES(BE_N)) sfct_core_i (
        .sys_clk(sys_clk), .srst(srst), .cs_n_pin(cs_n_pin),
        .sck_pin(sck_pin), .si_pin(si_pin), .reset_n_pin(reset_n_pin),
        .so_out(so_out), .so_oe(so_oe), .ready_busy_n(ready_busy_n),
        .page_addr(page_addr), .byte_addr(byte_addr), .buf_sel(buf_sel),
        .rd_req(rd_req), .clk_mode(clk_mode), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready));
    sfct_host sfct_host_i (.sys_clk(sys_clk), .cs_n_pin(cs_n_pin),
        .sck_pin(sck_pin), .si_pin(si_pin), .so_out(so_out));

    // ====================================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // Valid is held until ready is seen at a rising edge, or for at most 100 rising edges.
    task automatic push(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge sys_clk);
        rd_data = b;
        rd_valid = 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (rd_ready !== 1'b1 && n < 100);
        @(negedge sys_clk);
        rd_valid = 1'b0;
    endtask : push

    task automatic send_hdr(input logic [7:0] op, input logic md,
        input logic [23:0] a);
        logic [7:0] rx;
        sfct_host_i.frame_start(md);
        sfct_host_i.xfer(op, rx);
        for (int k = 2; k >= 0; k--) begin
            sfct_host_i.xfer(a[8*k+:8], rx);
        end
    endtask : send_hdr

    // ====================================================================
    // Scenarios
    task automatic test_status(input logic md, input logic [7:0] exp);
        logic [7:0] rx;
        sfct_host_i.frame_start(md);
        sfct_host_i.xfer(md ? OP_STATUS_SPI : OP_STATUS_IDLE, rx);
        sfct_host_i.xfer(8'h96, rx);
        check(rx, exp);
        check(so_oe, 1'b1);
        check(clk_mode, md);
        sfct_host_i.frame_end();
        repeat (4) @(negedge sys_clk);
        check(so_oe, 1'b0);
        $display("status read mode %0d done", md);
    endtask : test_status

    task automatic test_read(input logic [7:0] op, input logic md,
        input logic [2:0] rsv, input logic [11:0] pg, input logic [8:0] ba,
        input int dummies);
        logic [7:0] rx;
        int r0;
        r0 = req_seen;
        send_hdr(op, md, {rsv, pg, ba});
        fork
            begin
                push(op ^ 8'h3c);
                push(~op);
            end
        join_none
        for (int k = 0; k < dummies; k++) begin
            sfct_host_i.xfer(8'h69, rx);
        end
        check(req_seen, r0 + 1);
        check(byte_addr, ba);
        if (dummies == 4) begin
            check(page_addr, {rsv, pg});
        end else begin
            check(buf_sel, op[1]);
        end
        check(clk_mode, md);
        sfct_host_i.xfer(8'h5a, rx);
        check(rx, op ^ 8'h3c);
        sfct_host_i.xfer(8'ha5, rx);
        check(rx, 8'(~op));
        sfct_host_i.frame_end();
        repeat (4) @(negedge sys_clk);
        check(so_oe, 1'b0);
        $display("read %h done", op);
    endtask : test_read

    task automatic test_busy(input logic [7:0] op, input int n,
        input logic md, input logic poll);
        int t0;
        int dur;
        send_hdr(op, md, 24'h0a5c21);
        sfct_host_i.frame_end();
        t0 = cyc;
        while (ready_busy_n !== 1'b0 && cyc - t0 < 20) @(negedge sys_clk);
        check(cyc - t0 <= BUSY_LOW_CYC, 1'b1);
        if (poll) begin
            test_status(md, {1'b0, STATUS_ID[6:0]});
        end
        while (ready_busy_n !== 1'b1 && cyc - t0 < n + 100) begin
            @(negedge sys_clk);
        end
        dur = cyc - t0;
        check(dur >= n - 2 && dur <= n + 8, 1'b1);
        $display("busy %h lasted %0d cycles", op, dur);
    endtask : test_busy

    task automatic test_pin_reset();
        send_hdr(OP_BLOCK_ERASE, 1'b0, 24'h000000);
        sfct_host_i.frame_end();
        repeat (30) @(negedge sys_clk);
        check(ready_busy_n, 1'b0);
        reset_n_pin = 1'b0;
        repeat (500) @(negedge sys_clk);
        check(ready_busy_n, 1'b1);
        check(so_oe, 1'b0);
        reset_n_pin = 1'b1;
        repeat (RECOVER_CYC + 4) @(negedge sys_clk);
        test_status(1'b1, {1'b1, STATUS_ID[6:0]});
        $display("reset pin test done");
    endtask : test_pin_reset

    // Fill through the array port until refused, then drain by a read.
    task automatic test_fifo();
        logic [7:0] rx;
        for (int k = 0; k < FIFO_DEPTH; k++) begin
            push(8'(k) ^ 8'hc3);
        end
        check(rd_ready, 1'b0);
        push(8'h7e);
        check(rd_ready, 1'b0);
        send_hdr(OP_BUF2_RD_IDLE, 1'b0, 24'h000123);
        sfct_host_i.xfer(8'h00, rx);
        check(buf_sel, 1'b1);
        for (int k = 0; k < FIFO_DEPTH; k++) begin
            sfct_host_i.xfer(8'h00, rx);
            check(rx, 8'(k) ^ 8'hc3);
        end
        check(so_oe, 1'b1);
        sfct_host_i.frame_end();
        check(rd_ready, 1'b1);
        $display("fifo test done");
    endtask : test_fifo

    // ====================================================================
    initial begin
        repeat (20) @(negedge sys_clk);
        check(ready_busy_n, 1'b1);
        check(so_oe, 1'b0);
        srst = 1'b0;
        repeat (RECOVER_CYC + 8) @(negedge sys_clk);
        test_status(1'b0, {1'b1, STATUS_ID[6:0]});
        test_status(1'b1, {1'b1, STATUS_ID[6:0]});
        for (int k = 0; k < 8; k++) begin
            test_read(ops[k], 1'(k), 3'b000, 12'ha5c ^ 12'(k),
                9'h100 | 9'(k), (k % 4 < 2) ? 4 : 1);
        end
        test_read(OP_PAGE_RD_IDLE, 1'b0, 3'b101, 12'hfff, 9'h1ff, 4);
        test_busy(OP_XFER_BUF1, XFER_CYC, 1'b0, 1'b1);
        test_busy(OP_CMP_BUF2, XFER_CYC, 1'b1, 1'b0);
        test_busy(OP_PROG_ERASE_B1, PE_N, 1'b0, 1'b0);
        test_busy(OP_PROG_ERASE_B2, PE_N, 1'b1, 1'b0);
        test_busy(OP_PROG_ONLY_B1, PO_N, 1'b0, 1'b0);
        test_busy(OP_PROG_ONLY_B2, PO_N, 1'b1, 1'b0);
        test_busy(OP_PAGE_ERASE, ER_N, 1'b0, 1'b0);
        test_busy(OP_BLOCK_ERASE, BE_N, 1'b1, 1'b0);
        test_pin_reset();
        test_fifo();
        finish_test();
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        $display("ERROR at %0t ns: watchdog seen %h expected %h", $time,
            1'b0, 1'b1);
        finish_test();
    end
endmodule : serial_flash_command_timing_test
